// [hdl/comb_filter_error_control.v]
// Register access over Avalon-MM is this design's own decision.
`include "comb_error_defines.vh"
module comb_filter_error_control #(
    parameter W = 10
) (
    input  wire         CLK_SYS,
    input  wire         RST,
    input  wire [7:0]   AVS_ADDRESS,
    input  wire         AVS_READ,
    input  wire         AVS_WRITE,
    input  wire [31:0]  AVS_WRITEDATA,
    input  wire [3:0]   AVS_BYTEENABLE,
    output reg  [31:0]  AVS_READDATA,
    output wire         AVS_WAITREQUEST,
    input  wire [W-1:0] CHROMA_ERR_IN,
    input  wire [W-1:0] LUMA_ERR_IN,
    input  wire [W-1:0] LUT_IN,
    input  wire         PREFER_ALT,
    output wire [W-1:0] CHROMA_ERR_OUT,
    output reg  [W-1:0] LUMA_ERR_OUT,
    output wire [W-1:0] LUT_OUT,
    output reg  [2:0]   LINE_TAPS,
    output reg  [1:0]   COMB_KIND,
    output reg          D1_MODE,
    output reg          PAL_OK,
    output reg          ALT_SELECTED
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register slave: one wait cycle, so reads come from a register
    reg  [7:0] err_ctrl_reg;
    reg  [3:0] arch_reg;
    reg        ack_reg;
    wire       req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_reg;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ack_reg      <= 1'b0;
            err_ctrl_reg <= `ERR_CTRL_RESET;
            arch_reg     <= `ARCH_CTRL_RESET;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg) begin
                AVS_READDATA <= 32'h00000000;
                if (AVS_ADDRESS == `ERR_CTRL_INDEX) begin
                    AVS_READDATA <= {24'h000000, err_ctrl_reg};
                    if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
                        err_ctrl_reg <= AVS_WRITEDATA[7:0];
                    end
                end else if (AVS_ADDRESS == `ARCH_CTRL_INDEX) begin
                    AVS_READDATA <= {28'h0000000, arch_reg};
                    if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
                        arch_reg <= AVS_WRITEDATA[3:0];
                    end
                end else if (AVS_ADDRESS == `STATUS_INDEX) begin
                    AVS_READDATA <= {29'h0, D1_MODE, PAL_OK, ALT_SELECTED};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Architecture decode; taps bit2=0H, bit1=1H, bit0=2H; kind 0 line 1 field 2 frame
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            LINE_TAPS <= `ARCH_TAPS_RESET;
            COMB_KIND <= 2'h0;
            D1_MODE   <= 1'b0;
            PAL_OK    <= `ARCH_PAL_RESET;
        end else begin
            D1_MODE <= arch_reg[3];
            PAL_OK  <= 1'b0;
            case (arch_reg)
                4'h0: begin LINE_TAPS <= 3'h7; COMB_KIND <= 2'h0; PAL_OK <= 1'b1; end
                4'h1: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h0; end
                4'h2: begin LINE_TAPS <= 3'h3; COMB_KIND <= 2'h0; end
                4'h3: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h0; end
                4'h4: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h1; end
                4'h5: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h1; PAL_OK <= 1'b1; end
                4'h6: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h2; end
                4'h7: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h2; PAL_OK <= 1'b1; end
                4'h8: begin LINE_TAPS <= 3'h7; COMB_KIND <= 2'h0; end
                4'h9: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h0; end
                4'hA: begin LINE_TAPS <= 3'h3; COMB_KIND <= 2'h0; end
                4'hB: begin LINE_TAPS <= 3'h5; COMB_KIND <= 2'h0; end
                4'hC: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h1; end
                4'hD: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h3; end
                4'hE: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h2; end
                default: begin LINE_TAPS <= 3'h6; COMB_KIND <= 2'h2; end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error paths
    error_shaper #(.W(W)) chroma_shaper (
        .clk       (CLK_SYS),
        .rst       (RST),
        .transform (err_ctrl_reg[`TRANSFORM_MSB:`TRANSFORM_LSB]),
        .gain      (err_ctrl_reg[`CHROMA_GAIN_BIT]),
        .bypass    (err_ctrl_reg[`CHROMA_BYPASS_BIT]),
        .err_in    (CHROMA_ERR_IN),
        .err_out   (CHROMA_ERR_OUT)
    );

    lut_lowpass #(.W(W)) lut_filter (
        .clk    (CLK_SYS),
        .rst    (RST),
        .enable (err_ctrl_reg[`LUT_FILTER_BIT]),
        .din    (LUT_IN),
        .dout   (LUT_OUT)
    );

    // Luma: weighting is a 3/4 scale, then optional doubling with saturation
    wire [W+1:0] luma_w = err_ctrl_reg[`LUMA_WEIGHT_BYP_BIT] ? {2'h0, LUMA_ERR_IN} :
                          {2'h0, LUMA_ERR_IN} - {4'h0, LUMA_ERR_IN[W-1:2]};
    wire [W+1:0] luma_g = err_ctrl_reg[`LUMA_GAIN_BIT] ? {luma_w[W:0], 1'b0} : luma_w;
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            LUMA_ERR_OUT <= {W{1'b0}};
        end else begin
            LUMA_ERR_OUT <= (|luma_g[W+1:W]) ? {W{1'b1}} : luma_g[W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Adaption decision; slow mode needs a steady run before switching,
    // trading response for freedom from pixel-rate flicker
    reg [3:0] run_reg;
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ALT_SELECTED <= 1'b0;
            run_reg      <= 4'h0;
        end else if (err_ctrl_reg[`FAST_ADAPT_BIT]) begin
            ALT_SELECTED <= PREFER_ALT;
            run_reg      <= 4'h0;
        end else if (PREFER_ALT == ALT_SELECTED) begin
            run_reg <= 4'h0;
        end else if (run_reg == `ADAPT_HOLD_COUNT) begin
            ALT_SELECTED <= PREFER_ALT;
            run_reg      <= 4'h0;
        end else begin
            run_reg <= run_reg + 4'h1;
        end
    end
endmodule // comb_filter_error_control

// [hdl/comb_error_defines.vh]
`ifndef COMB_ERROR_DEFINES_VH
`define COMB_ERROR_DEFINES_VH
// Behaviour
// - Codes 0001/0010/0011: NTSC 3-line (0H,1H), 3-line (1H,2H), 2-line (0H,1H).
// - Codes 0100/0110 NTSC field/frame comb; 0101/0111 NTSC-or-PAL field/frame comb.
// - D1: 1000 three-line, 1001 three-line (0H,1H), 1111 frame comb.
// - Chroma error gain bit doubles chroma error levels when set.
// - Luma error gain bit doubles luma error levels when set.
// - Chroma error bypass bit high bypasses chroma error processing; the code forces CHROMA_ERR_OUT to zero instead.
// - Lookup filter enable applies low-pass to lookup table output.
// - Adaption speed high: architecture chosen independently per pixel.
// - Adaption speed low: architecture decision is filtered.
// - Luma weighting bypass skips luma fail weighting.

// Register word addresses
`define ARCH_CTRL_INDEX      8'h0C
`define ERR_CTRL_INDEX       8'h0D
`define STATUS_INDEX         8'h10
// Error control fields
`define TRANSFORM_MSB        7
`define TRANSFORM_LSB        6
`define CHROMA_GAIN_BIT      5
`define LUMA_GAIN_BIT        4
`define CHROMA_BYPASS_BIT    3
`define LUT_FILTER_BIT       2
`define FAST_ADAPT_BIT       1
`define LUMA_WEIGHT_BYP_BIT  0
`define ERR_CTRL_RESET       8'h00
`define ARCH_CTRL_RESET      4'h0
`define ARCH_TAPS_RESET      3'h7
`define ARCH_PAL_RESET       1'b1
// Decision filter hold, in pixels
`define ADAPT_HOLD_COUNT     4'h3
`endif

// [hdl/error_shaper.v]
`include "comb_error_defines.vh"
module error_shaper #(
    parameter W = 10
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [1:0]   transform,
    input  wire         gain,
    input  wire         bypass,
    input  wire [W-1:0] err_in,
    output reg  [W-1:0] err_out
);
    reg [W+1:0] scaled;
    reg [W+1:0] gained;
    always @* begin
        // Scale so that error per subcarrier cycle matches across rates
        case (transform)
            2'h0:    scaled = {2'h0, err_in};
            2'h1:    scaled = {2'h0, err_in} + {3'h0, err_in[W-1:1]};
            2'h2:    scaled = {2'h0, err_in} - {4'h0, err_in[W-1:2]};
            default: scaled = {2'h0, err_in} - {3'h0, err_in[W-1:1]} + {5'h0, err_in[W-1:3]};
        endcase
        gained = gain ? {scaled[W:0], 1'b0} : scaled;
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            err_out <= {W{1'b0}};
        end else if (bypass) begin
            err_out <= {W{1'b0}};
        end else if (|gained[W+1:W]) begin
            err_out <= {W{1'b1}};
        end else begin
            err_out <= gained[W-1:0];
        end
    end
endmodule // error_shaper

// [hdl/lut_lowpass.v]
module lut_lowpass #(
    parameter W = 10
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         enable,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg  [W-1:0] prev_reg;
    wire [W:0]   sum = {1'b0, din} + {1'b0, prev_reg};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= {W{1'b0}};
            dout     <= {W{1'b0}};
        end else begin
            prev_reg <= din;
            dout     <= enable ? sum[W:1] : din;
        end
    end
endmodule // lut_lowpass

// [sim/comb_ctrl_chk.sv]
module comb_ctrl_chk (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic [7:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        PREFER_ALT,
    input wire logic [2:0]  LINE_TAPS,
    input wire logic [1:0]  COMB_KIND,
    input wire logic        D1_MODE,
    input wire logic        PAL_OK,
    input wire logic        ALT_SELECTED
);
    timeunit 1ns;
    timeprecision 1ps;
    wire rd_ok   = AVS_READ && !AVS_WAITREQUEST;
    wire arch_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h0C && AVS_BYTEENABLE[0];
    wire mapped  = AVS_ADDRESS == 8'h0C || AVS_ADDRESS == 8'h0D || AVS_ADDRESS == 8'h10;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("access not answered after one wait cycle");
    idle_nowait_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest high with no access");
    upper_zero_a: assert property (rd_ok |-> AVS_READDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    unmapped_zero_a: assert property (rd_ok && !mapped |-> AVS_READDATA == 32'h00000000)
        else $error("unmapped read not zero");
    // Architecture outputs may move only as a result of a write to the code register
    cfg_after_write_a: assert property ($changed({LINE_TAPS, COMB_KIND, D1_MODE, PAL_OK}) |-> $past(arch_wr, 1) || $past(arch_wr, 2))
        else $error("architecture outputs changed without a write");
    alt_follow_a: assert property ($changed(ALT_SELECTED) |-> ALT_SELECTED == $past(PREFER_ALT))
        else $error("selection moved away from the preferred comb");
    kind_mixed_a: assert property (COMB_KIND == 2'h3 |-> D1_MODE)
        else $error("field-or-line kind outside component mode");
    taps_outer_a: assert property (LINE_TAPS == 3'h5 |-> D1_MODE && COMB_KIND == 2'h0)
        else $error("outer-line taps outside component line comb");
endmodule // comb_ctrl_chk

bind comb_filter_error_control comb_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PREFER_ALT(PREFER_ALT), .LINE_TAPS(LINE_TAPS),
    .COMB_KIND(COMB_KIND), .D1_MODE(D1_MODE), .PAL_OK(PAL_OK), .ALT_SELECTED(ALT_SELECTED));

// [sim/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, pref = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, q, e;
    logic [3:0]  be = 4'hF;
    logic [9:0]  c_in = 10'h000, l_in = 10'h000, x_in = 10'h000;
    wire  [31:0] rdat;
    wire         wait_req, d1, pal, alt;
    wire  [9:0]  c_out, l_out, x_out;
    wire  [2:0]  taps;
    wire  [1:0]  kind;
    logic [12:0] r;
    int          failures = 0, check_count = 0, cycles = 0;
    // Row: code, taps, taps known, kind, d1, pal, pal known
    logic [12:0] arch_rows [15] = '{13'h03A1, 13'h04E1, 13'h07A1, 13'h0809, 13'h0A0B,
        13'h0C11, 13'h0E13, 13'h11E4, 13'h13A4, 13'h14E4, 13'h1764, 13'h180C, 13'h1A1C,
        13'h1C14, 13'h1E14};
    // Row: control byte, chroma out, luma out, both inputs at 0x050
    logic [31:0] err_rows [7] = '{32'h01050050, 32'h41078050, 32'h8103C050, 32'hC1032050,
        32'h310A00A0, 32'h09000050, 32'h0005003C};
    comb_filter_error_control #(.W(10)) u_dut (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .CHROMA_ERR_IN(c_in),
        .LUMA_ERR_IN(l_in), .LUT_IN(x_in), .PREFER_ALT(pref), .CHROMA_ERR_OUT(c_out),
        .LUMA_ERR_OUT(l_out), .LUT_OUT(x_out), .LINE_TAPS(taps), .COMB_KIND(kind),
        .D1_MODE(d1), .PAL_OK(pal), .ALT_SELECTED(alt));
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #2 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] s);
        check_count++;
        if (s !== ex) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, ex, s);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge, before that edge's updates land;
    // the leading edge keeps an idle cycle between calls so no signal is assigned twice at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic lut_step(input logic [7:0] ctrl, input logic [9:0] ex);
        bus(1'b1, 8'h0D, ctrl);
        x_in <= 10'h000;
        repeat (4) @(posedge clk);
        x_in <= 10'h064;
        do @(negedge clk); while (x_out === 10'h000);
        chk("lut out", ex, x_out);
    endtask
    task automatic pulse(input logic [7:0] ctrl, input logic ex);
        bus(1'b1, 8'h0D, ctrl);
        pref <= 1'b1;
        repeat (8) @(posedge clk);
        pref <= 1'b0;
        @(posedge clk);
        pref <= 1'b1;
        @(negedge clk);
        chk("alt pulse", ex, alt);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("taps reset", 32'h7, taps);
        bus(1'b0, 8'h10, 8'h00);
        chk("status reset", 32'h2, q);
        foreach (arch_rows[i]) begin
            r = arch_rows[i];
            bus(1'b1, 8'h0C, {4'h0, r[12:9]});
            @(negedge clk);
            if (r[5]) chk("taps", r[8:6], taps);
            chk("kind", r[4:3], kind);
            chk("d1", r[2], d1);
            if (r[0]) chk("pal", r[1], pal);
            bus(1'b0, 8'h0C, 8'h00);
            chk("arch readback", r[12:9], q);
        end
        c_in <= 10'h050;
        l_in <= 10'h050;
        foreach (err_rows[i]) begin
            e = err_rows[i];
            bus(1'b1, 8'h0D, e[31:24]);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("chroma err", e[21:12], c_out);
            chk("luma err", e[9:0], l_out);
        end
        // Doubling past full scale clips instead of wrapping
        @(posedge clk);
        c_in <= 10'h300;
        l_in <= 10'h300;
        bus(1'b1, 8'h0D, 8'h31);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("chroma clip", 32'h3FF, c_out);
        chk("luma clip", 32'h3FF, l_out);
        // Reset in mid-run must restore the decode and clear the control byte
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("taps mid reset", 32'h7, taps);
        bus(1'b0, 8'h0D, 8'h00);
        chk("ctrl mid reset", 32'h0, q);
        // A write with lane 0 disabled must leave the control byte alone
        @(posedge clk);
        be <= 4'h0;
        bus(1'b1, 8'h0D, 8'hFF);
        be <= 4'hF;
        bus(1'b0, 8'h0D, 8'h00);
        chk("masked write", 32'h0, q);
        bus(1'b1, 8'h20, 8'hFF);
        bus(1'b0, 8'h20, 8'h00);
        chk("unmapped read", 32'h0, q);
        lut_step(8'h00, 10'h064);
        lut_step(8'h04, 10'h032);
        pulse(8'h00, 1'b1);
        pulse(8'h02, 1'b0);
        tally_and_finish();
    end
endmodule // tb
